// file: hw/ivp_consts.vh
// constants for the interrupt vector and priority block
`ifndef IVP_CONSTS_VH
`define IVP_CONSTS_VH

// apb register byte offsets
`define IVP_OFS_STATUS 8'h00
`define IVP_OFS_MASK 8'h04
`define IVP_OFS_ACTIVE 8'h08
`define IVP_OFS_RSTVEC 8'h0C
`define IVP_OFS_SP 8'h10

// status and mask layout: flags 1..17 in bits 1..17
`define IVP_ST_FLAG_LO 1
`define IVP_ST_FLAG_HI 17
`define IVP_ST_STACK_FAULT 18
`define IVP_ST_WIDTH 19
`define IVP_MASK_RESET 19'h00000

// vector map
`define IVP_VEC_RESET 16'hFFFE
`define IVP_VEC_SWI 16'hFFFC
`define IVP_VEC_FLAG1 16'hFFFA
`define IVP_VEC_FLAG2 16'hFFF8
`define IVP_VEC_FLAG3 16'hFFF6
`define IVP_VEC_FLAG4 16'hFFF4
`define IVP_VEC_FLAG5 16'hFFF2
`define IVP_VEC_FLAG6 16'hFFF0
`define IVP_VEC_FLAG7 16'hFFEE
`define IVP_VEC_FLAG8 16'hFFEC
`define IVP_VEC_FLAG9 16'hFFEA
`define IVP_VEC_FLAG10 16'hFFE8
`define IVP_VEC_FLAG11 16'hFFE6
`define IVP_VEC_FLAG12 16'hFFE4
`define IVP_VEC_FLAG13 16'hFFE2
`define IVP_VEC_FLAG14 16'hFFE0
`define IVP_VEC_FLAG15 16'hFFDE
`define IVP_VEC_FLAG16 16'hFFDC
`define IVP_VEC_LOWEST 16'hFFDA
`define IVP_WDOG_CLEAR_ADDR 16'hFFFF

// on-chip ram window
`define IVP_RAM_FIRST 16'h0060
`define IVP_RAM_LAST 16'h025F
`define IVP_RAM_BYTES 512

// stack
`define IVP_SP_RESET 16'h00FF
`define IVP_STACK_BYTES 3'h5

// source codes held while a service is in progress
`define IVP_SRC_RESET 5'h00
`define IVP_SRC_SWI 5'h12

`endif

// file: hw/ivp_prio.v
// fixed-priority picker: lowest set index wins
`timescale 1ns/10ps
module ivp_prio #(
   parameter N = 17
) (
   // request vector, bit 0 ranks highest
   input wire [N-1:0] req,
   // result
   output reg any,
   output reg [4:0] index
);
   integer i;

   always @* begin
      any = 1'b0;
      index = 5'h00;
      for (i = N - 1; i >= 0; i = i - 1) begin
         if (req[i]) begin
            any = 1'b1;
            index = i[4:0];
         end
      end
   end
endmodule

// file: hw/ivp_ctrl.v
// interrupt vector selection, stacking, ram and watchdog clear
`timescale 1ns/10ps
`include "ivp_consts.vh"

module ivp_ctrl #(
   parameter NFLAG = 17,
   parameter RAM_BYTES = `IVP_RAM_BYTES
) (
   // clock and reset
   input wire pclk,
   input wire presetn,
   // apb slave
   input wire psel,
   input wire penable,
   input wire pwrite,
   input wire [7:0] paddr,
   input wire [31:0] pwdata,
   output reg [31:0] prdata,
   output wire pready,
   output wire pslverr,
   // peripheral request flags, bit 0 is flag 1
   input wire [NFLAG-1:0] request_flags,
   // cpu memory port
   input wire cpu_rd,
   input wire cpu_wr,
   input wire [15:0] cpu_addr,
   input wire [7:0] cpu_wdata,
   output reg [7:0] cpu_rdata,
   // cpu interrupt handshake
   input wire cpu_int_ack,
   input wire software_interrupt,
   input wire sp_load,
   input wire [15:0] sp_value,
   input wire [15:0] cpu_pc,
   input wire [7:0] cpu_x,
   input wire [7:0] cpu_a,
   input wire [7:0] cpu_ccr,
   output reg [15:0] stack_pointer,
   output wire cpu_busy,
   output reg vector_strobe,
   output reg [15:0] vector_addr,
   // system outputs
   output reg watchdog_clear,
   output wire irq
);
   localparam S_IDLE = 2'h0;
   localparam S_PUSH = 2'h1;
   localparam S_VEC = 2'h2;
   localparam S_BOOT = 2'h3;

   reg [1:0] state;
   reg [2:0] push_cnt;
   reg [4:0] active_src;
   reg [`IVP_ST_WIDTH-1:0] status;
   reg [`IVP_ST_WIDTH-1:0] mask;
   reg [15:0] reset_vector;
   reg [7:0] ram [0:RAM_BYTES-1];

   wire [`IVP_ST_WIDTH-1:0] pending;
   wire pick_any;
   wire [4:0] pick_idx;
   wire setup;
   wire access;
   wire wr_access;
   wire mapped;
   wire sp_in_ram;
   wire [7:0] push_byte;
   wire stack_fault_evt;
   wire start_int;
   wire start_swi;

   reg [`IVP_ST_WIDTH-1:0] next_status;
   reg [`IVP_ST_WIDTH-1:0] hw_set;
   reg [`IVP_ST_WIDTH-1:0] hw_clr;

   // address in ram window
   function in_ram;
      input [15:0] a;
      begin
         in_ram = (a >= `IVP_RAM_FIRST) && (a <= `IVP_RAM_LAST);
      end
   endfunction

   // ram index of an address
   function [8:0] ram_idx;
      input [15:0] a;
      reg [15:0] d;
      begin
         d = a - `IVP_RAM_FIRST;
         ram_idx = d[8:0];
      end
   endfunction

   // vector address of a source code, even address of the byte pair
   function [15:0] vec_of;
      input [4:0] src;
      begin
         case (src)
            5'h01: vec_of = `IVP_VEC_FLAG1;
            5'h02: vec_of = `IVP_VEC_FLAG2;
            5'h03: vec_of = `IVP_VEC_FLAG3;
            5'h04: vec_of = `IVP_VEC_FLAG4;
            5'h05: vec_of = `IVP_VEC_FLAG5;
            5'h06: vec_of = `IVP_VEC_FLAG6;
            5'h07: vec_of = `IVP_VEC_FLAG7;
            5'h08: vec_of = `IVP_VEC_FLAG8;
            5'h09: vec_of = `IVP_VEC_FLAG9;
            5'h0A: vec_of = `IVP_VEC_FLAG10;
            5'h0B: vec_of = `IVP_VEC_FLAG11;
            5'h0C: vec_of = `IVP_VEC_FLAG12;
            5'h0D: vec_of = `IVP_VEC_FLAG13;
            5'h0E: vec_of = `IVP_VEC_FLAG14;
            5'h0F: vec_of = `IVP_VEC_FLAG15;
            5'h10: vec_of = `IVP_VEC_FLAG16;
            5'h11: vec_of = `IVP_VEC_LOWEST;
            `IVP_SRC_SWI: vec_of = `IVP_VEC_SWI;
            `IVP_SRC_RESET: vec_of = `IVP_VEC_RESET;
            default: vec_of = `IVP_VEC_RESET;
         endcase
      end
   endfunction

   // unmasked pending flags, bit 1 = flag 1, bit 18 = stack fault
   assign pending = status & mask;

   ivp_prio #(
      .N(NFLAG)
   ) u_prio (
      .req(pending[`IVP_ST_FLAG_HI:`IVP_ST_FLAG_LO]),
      .any(pick_any),
      .index(pick_idx)
   );

   // one level line, also the request to the cpu
   assign irq = |pending;

   // apb
   assign setup = psel & ~penable;
   assign access = psel & penable;
   assign wr_access = access & pwrite;
   assign pready = 1'b1;
   assign mapped = (paddr == `IVP_OFS_STATUS) || (paddr == `IVP_OFS_MASK) ||
                   (paddr == `IVP_OFS_ACTIVE) || (paddr == `IVP_OFS_RSTVEC) ||
                   (paddr == `IVP_OFS_SP);
   assign pslverr = access & ~mapped;

   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata <= 32'h00000000;
      end else if (setup) begin
         case (paddr)
            `IVP_OFS_STATUS: prdata <= {13'h0000, status};
            `IVP_OFS_MASK: prdata <= {13'h0000, mask};
            `IVP_OFS_ACTIVE: prdata <= {vector_addr, 8'h00, cpu_busy,
                                        2'h0, active_src};
            `IVP_OFS_RSTVEC: prdata <= {16'h0000, reset_vector};
            `IVP_OFS_SP: prdata <= {16'h0000, stack_pointer};
            default: prdata <= 32'h00000000;
         endcase
      end
   end

   always @(posedge pclk or negedge presetn) begin
      if (!presetn)
         mask <= `IVP_MASK_RESET;
      else if (wr_access && paddr == `IVP_OFS_MASK)
         mask <= pwdata[`IVP_ST_WIDTH-1:0];
   end

   // vector store contents are kept across reset
   always @(posedge pclk) begin
      if (wr_access && paddr == `IVP_OFS_RSTVEC)
         reset_vector <= pwdata[15:0];
   end

   // sticky status: hardware set wins over any clear
   assign sp_in_ram = in_ram(stack_pointer);
   assign stack_fault_evt = (state == S_PUSH) & ~sp_in_ram;

   always @* begin
      hw_set = {`IVP_ST_WIDTH{1'b0}};
      hw_set[`IVP_ST_FLAG_HI:`IVP_ST_FLAG_LO] = request_flags;
      hw_set[`IVP_ST_STACK_FAULT] = stack_fault_evt;
      hw_clr = {`IVP_ST_WIDTH{1'b0}};
      if (wr_access && paddr == `IVP_OFS_STATUS)
         hw_clr = pwdata[`IVP_ST_WIDTH-1:0];
      if (start_int)
         hw_clr[pick_idx + 5'h01] = 1'b1;
      next_status = (status & ~hw_clr) | hw_set;
      next_status[0] = 1'b0;
   end

   always @(posedge pclk or negedge presetn) begin
      if (!presetn)
         status <= {`IVP_ST_WIDTH{1'b0}};
      else
         status <= next_status;
   end

   // service start: software interrupt ahead of flagged requests
   assign start_swi = (state == S_IDLE) & software_interrupt;
   assign start_int = (state == S_IDLE) & ~software_interrupt &
                      cpu_int_ack & pick_any;
   assign cpu_busy = (state != S_IDLE);

   // stacked order: pc low, pc high, x, a, ccr; no upper index byte
   assign push_byte = (push_cnt == 3'h0) ? cpu_pc[7:0] :
                      (push_cnt == 3'h1) ? cpu_pc[15:8] :
                      (push_cnt == 3'h2) ? cpu_x :
                      (push_cnt == 3'h3) ? cpu_a : cpu_ccr;

   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state <= S_BOOT;
         push_cnt <= 3'h0;
         active_src <= `IVP_SRC_RESET;
         stack_pointer <= `IVP_SP_RESET;
         vector_strobe <= 1'b0;
         vector_addr <= `IVP_VEC_RESET;
      end else begin
         vector_strobe <= 1'b0;
         case (state)
            S_BOOT: begin
               // first fetch after reset goes through the reset vector
               active_src <= `IVP_SRC_RESET;
               state <= S_VEC;
            end
            S_IDLE: begin
               if (sp_load)
                  stack_pointer <= sp_value;
               if (start_swi) begin
                  active_src <= `IVP_SRC_SWI;
                  push_cnt <= 3'h0;
                  state <= S_PUSH;
               end else if (start_int) begin
                  active_src <= pick_idx + 5'h01;
                  push_cnt <= 3'h0;
                  state <= S_PUSH;
               end
            end
            S_PUSH: begin
               stack_pointer <= stack_pointer - 16'h0001;
               push_cnt <= push_cnt + 3'h1;
               if (push_cnt == `IVP_STACK_BYTES - 3'h1)
                  state <= S_VEC;
            end
            S_VEC: begin
               vector_addr <= vec_of(active_src);
               vector_strobe <= 1'b1;
               state <= S_IDLE;
            end
            default: state <= S_IDLE;
         endcase
      end
   end

   // ram: stacking writes take the port over the cpu
   always @(posedge pclk) begin
      if (state == S_PUSH && sp_in_ram)
         ram[ram_idx(stack_pointer)] <= push_byte;
      else if (state == S_IDLE && cpu_wr && in_ram(cpu_addr))
         ram[ram_idx(cpu_addr)] <= cpu_wdata;
   end

   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cpu_rdata <= 8'h00;
         watchdog_clear <= 1'b0;
      end else begin
         watchdog_clear <= cpu_wr & ~cpu_busy &
                           (cpu_addr == `IVP_WDOG_CLEAR_ADDR);
         if (cpu_rd) begin
            if (in_ram(cpu_addr))
               cpu_rdata <= ram[ram_idx(cpu_addr)];
            else if (cpu_addr == `IVP_WDOG_CLEAR_ADDR)
               cpu_rdata <= reset_vector[7:0];
            else if (cpu_addr == `IVP_VEC_RESET)
               cpu_rdata <= reset_vector[15:8];
            else
               cpu_rdata <= 8'h00;
         end
      end
   end
endmodule

// file: tb/ivp_ctrl_assertions.sv
// port assertions for the vector block
`timescale 1ns/10ps
module ivp_ctrl_chk (
   // clock and reset
   input wire pclk,
   input wire presetn,
   // apb
   input wire psel,
   input wire penable,
   input wire [7:0] paddr,
   input wire pready,
   input wire pslverr,
   // cpu side
   input wire irq,
   input wire cpu_int_ack,
   input wire software_interrupt,
   input wire cpu_wr,
   input wire [15:0] cpu_addr,
   input wire cpu_busy,
   input wire vector_strobe,
   input wire [15:0] vector_addr,
   input wire [15:0] stack_pointer,
   input wire watchdog_clear
);
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   sequence take_s;
      !cpu_busy && (software_interrupt || cpu_int_ack && irq);
   endsequence
   sequence swi_s;
      !cpu_busy && software_interrupt;
   endsequence
   take_strobe_a: assert property (take_s |-> ##7 vector_strobe)
      else $error("vector strobe late");
   busy_five_a: assert property (take_s |=> cpu_busy [*5])
      else $error("busy too short");
   sp_five_a: assert property (take_s |-> ##7
      stack_pointer == $past(stack_pointer, 7) - 16'h0005)
      else $error("five bytes not stacked");
   swi_vec_a: assert property (swi_s |-> ##7 vector_addr == 16'hFFFC)
      else $error("bad swi vector");
   vec_even_a: assert property (vector_strobe |->
      !vector_addr[0] && vector_addr >= 16'hFFDA)
      else $error("bad vector address");
   wd_clear_a: assert property (
      cpu_wr && cpu_addr == 16'hFFFF && !cpu_busy |=> watchdog_clear)
      else $error("watchdog not cleared");
   apb_err_a: assert property (psel && penable && paddr > 8'h10 |-> pslverr)
      else $error("unmapped not refused");
   apb_ready_a: assert property (psel && penable |-> pready)
      else $error("apb not ready");
endmodule

// file: tb/ivp_cpu_model.sv
// cpu core stand-in: requests service, supplies state
`timescale 1ns/10ps
module ivp_cpu_model (
   // clock and reset
   input wire pclk,
   input wire presetn,
   // handshake
   input wire ack_req,
   input wire cpu_busy,
   output reg cpu_int_ack,
   // state to stack, no upper index byte
   output wire [15:0] cpu_pc,
   output wire [7:0] cpu_x,
   output wire [7:0] cpu_a,
   output wire [7:0] cpu_ccr
);
   assign cpu_pc = 16'hA5C3;
   assign cpu_x = 8'h11;
   assign cpu_a = 8'h22;
   assign cpu_ccr = 8'h33;
   // ack held until service starts
   always @(posedge pclk or negedge presetn) begin
      if (!presetn)
         cpu_int_ack <= 1'b0;
      else if (cpu_busy)
         cpu_int_ack <= 1'b0;
      else if (ack_req)
         cpu_int_ack <= 1'b1;
   end
endmodule

// file: tb/tb_interrupt_vector_priority.sv
// bench for the interrupt vector block
`timescale 1ns/10ps
`include "ivp_consts.vh"
module tb_interrupt_vector_priority;
   reg pclk, presetn, psel, penable, pwrite, cpu_rd, cpu_wr, e;
   reg software_interrupt, sp_load, ack_req;
   reg [7:0] paddr, cpu_wdata;
   reg [31:0] pwdata, d;
   reg [16:0] request_flags;
   reg [15:0] cpu_addr, sp_value;
   wire [31:0] prdata;
   wire [15:0] stack_pointer, vector_addr, cpu_pc;
   wire [7:0] cpu_rdata, cpu_x, cpu_a, cpu_ccr;
   wire pready, pslverr, cpu_busy, vector_strobe, watchdog_clear, irq;
   wire cpu_int_ack;
   integer errors, samples_checked, n, i;
   integer cyc = 0;
   ivp_ctrl uut (.pclk(pclk), .presetn(presetn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .request_flags(request_flags), .cpu_rd(cpu_rd), .cpu_wr(cpu_wr),
      .cpu_addr(cpu_addr), .cpu_wdata(cpu_wdata), .cpu_rdata(cpu_rdata),
      .cpu_int_ack(cpu_int_ack), .software_interrupt(software_interrupt),
      .sp_load(sp_load), .sp_value(sp_value), .cpu_pc(cpu_pc),
      .cpu_x(cpu_x), .cpu_a(cpu_a), .cpu_ccr(cpu_ccr),
      .stack_pointer(stack_pointer), .cpu_busy(cpu_busy),
      .vector_strobe(vector_strobe), .vector_addr(vector_addr),
      .watchdog_clear(watchdog_clear), .irq(irq));
   ivp_cpu_model cpu_m (.pclk(pclk), .presetn(presetn),
      .ack_req(ack_req), .cpu_busy(cpu_busy), .cpu_int_ack(cpu_int_ack),
      .cpu_pc(cpu_pc), .cpu_x(cpu_x), .cpu_a(cpu_a), .cpu_ccr(cpu_ccr));
   task chk(input [32:0] seen, input [32:0] exp);
      begin
         samples_checked = samples_checked + 1;
         if (seen !== exp) begin
            errors = errors + 1;
            $display("mismatch t=%0t seen=%h exp=%h", $time, seen, exp);
         end
      end
   endtask
   task end_of_test;
      begin
         $display("checks %0d errors %0d", samples_checked, errors);
         if (errors == 0 && samples_checked > 0)
            $display("Simulation passed");
         else
            $display("Simulation failed");
         $finish;
      end
   endtask
   task apb(input w, input [7:0] a, input [31:0] wd);
      begin
         @(posedge pclk);
         psel <= 1'b1;
         pwrite <= w;
         paddr <= a;
         pwdata <= wd;
         @(posedge pclk);
         penable <= 1'b1;
         @(posedge pclk);
         while (pready !== 1'b1) @(posedge pclk);
         d = prdata;
         e = pslverr;
         psel <= 1'b0;
         penable <= 1'b0;
         #1;
      end
   endtask
   task cpu(input w, input [15:0] a, input [7:0] wd);
      begin
         @(posedge pclk);
         cpu_rd <= !w;
         cpu_wr <= w;
         cpu_addr <= a;
         cpu_wdata <= wd;
         @(posedge pclk);
         cpu_rd <= 1'b0;
         cpu_wr <= 1'b0;
         #1;
      end
   endtask
   task ram(input [15:0] a, input [7:0] x);
      begin
         cpu(1'b1, a, 8'h5A);
         cpu(1'b0, a, 8'h00);
         chk(cpu_rdata, x);
      end
   endtask
   task vec(input [15:0] x);
      begin
         i = 0;
         while (vector_strobe !== 1'b1 && i < 30) begin
            @(posedge pclk);
            #1;
            i = i + 1;
         end
         chk({vector_strobe, vector_addr}, {1'b1, x});
      end
   endtask
   task flag(input [16:0] f);
      begin
         @(posedge pclk);
         request_flags <= f;
         @(posedge pclk);
         request_flags <= 17'h00000;
         #1;
      end
   endtask
   task serve(input [15:0] x);
      begin
         @(posedge pclk);
         ack_req <= 1'b1;
         @(posedge pclk);
         ack_req <= 1'b0;
         vec(x);
      end
   endtask
   initial begin
      pclk = 1'b0;
      forever #20 pclk = ~pclk;
   end
   always @(posedge pclk) begin
      cyc <= cyc + 1;
      if (cyc > 5000) begin
         errors = errors + 1;
         end_of_test;
      end
   end
   initial begin
      errors = 0;
      samples_checked = 0;
      {presetn, psel, penable, pwrite, cpu_rd, cpu_wr} = 6'h00;
      {software_interrupt, sp_load, ack_req} = 3'h0;
      {paddr, cpu_wdata, pwdata, request_flags} = 65'h0;
      {cpu_addr, sp_value} = 32'h0;
      repeat (2) @(posedge pclk);
      presetn <= 1'b1;
      vec(16'hFFFE);
      chk(stack_pointer, 16'h00FF);
      apb(1'b1, `IVP_OFS_RSTVEC, 32'h1234);
      cpu(1'b0, 16'hFFFE, 8'h00);
      chk(cpu_rdata, 8'h12);
      cpu(1'b1, 16'hFFFF, 8'h00);
      chk(watchdog_clear, 1'b1);
      cpu(1'b0, 16'hFFFF, 8'h00);
      chk(cpu_rdata, 8'h34);
      ram(16'h0060, 8'h5A);
      ram(16'h025F, 8'h5A);
      ram(16'h005F, 8'h00);
      ram(16'h0260, 8'h00);
      flag(17'h00001);
      chk(irq, 1'b0);
      apb(1'b1, `IVP_OFS_MASK, 32'h3FFFE);
      chk(irq, 1'b1);
      apb(1'b0, `IVP_OFS_STATUS, 32'h0);
      chk(d, 32'h2);
      apb(1'b1, `IVP_OFS_STATUS, 32'h2);
      chk(irq, 1'b0);
      for (n = 17; n > 0; n = n - 1) begin
         flag(17'h00001 << (n - 1));
         serve(16'hFFFA - 2 * (n - 1));
      end
      chk(stack_pointer, 16'h00AA);
      for (n = 0; n < 5; n = n + 1) begin
         cpu(1'b0, 16'h00AF - n, 8'h00);
         chk(cpu_rdata, (40'hC3A5112233 >> (32 - 8 * n)) & 40'hFF);
      end
      flag(17'h10001);
      serve(16'hFFFA);
      serve(16'hFFDA);
      @(posedge pclk);
      software_interrupt <= 1'b1;
      @(posedge pclk);
      software_interrupt <= 1'b0;
      vec(16'hFFFC);
      @(posedge pclk);
      sp_load <= 1'b1;
      sp_value <= 16'h0200;
      @(posedge pclk);
      sp_load <= 1'b0;
      #1;
      chk(stack_pointer, 16'h0200);
      apb(1'b0, `IVP_OFS_SP, 32'h0);
      chk(d, 32'h00000200);
      apb(1'b0, `IVP_OFS_ACTIVE, 32'h0);
      chk(d, 32'hFFFC0012);
      // stack outside ram: pushes dropped, fault flag raised
      @(posedge pclk);
      sp_load <= 1'b1;
      sp_value <= 16'h0300;
      @(posedge pclk);
      sp_load <= 1'b0;
      software_interrupt <= 1'b1;
      @(posedge pclk);
      software_interrupt <= 1'b0;
      vec(16'hFFFC);
      apb(1'b0, `IVP_OFS_STATUS, 32'h0);
      chk(d, 32'h00040000);
      chk(stack_pointer, 16'h02FB);
      // reset in mid-run keeps the stored reset vector
      @(posedge pclk);
      presetn <= 1'b0;
      @(posedge pclk);
      presetn <= 1'b1;
      vec(16'hFFFE);
      chk(stack_pointer, 16'h00FF);
      cpu(1'b0, 16'hFFFF, 8'h00);
      chk(cpu_rdata, 8'h34);
      apb(1'b0, `IVP_OFS_STATUS, 32'h0);
      chk(d, 32'h00000000);
      apb(1'b0, 8'h20, 32'h0);
      chk({e, d}, {1'b1, 32'h0});
      end_of_test;
   end
endmodule
bind ivp_ctrl ivp_ctrl_chk chk_i (.pclk(pclk), .presetn(presetn),
   .psel(psel), .penable(penable), .paddr(paddr), .pready(pready),
   .pslverr(pslverr), .irq(irq), .cpu_int_ack(cpu_int_ack),
   .software_interrupt(software_interrupt), .cpu_wr(cpu_wr),
   .cpu_addr(cpu_addr), .cpu_busy(cpu_busy),
   .vector_strobe(vector_strobe), .vector_addr(vector_addr),
   .stack_pointer(stack_pointer), .watchdog_clear(watchdog_clear));
